// >>> hw/pss_pkg.sv
// Package: register map, field layout and reset values of the PWM submodule.
// Assumes a 32-bit APB slave with one aligned word per register.
package pss_pkg;
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_PERIOD_OFS = 8'h04;
    localparam logic [7:0] REG_WIDTH_OFS = 8'h08;
    localparam logic [7:0] REG_COUNT_OFS = 8'h0c;
    localparam logic [7:0] REG_ARB_OFS = 8'h10;
    localparam int FLAG_POS = 15;
    localparam int IL_LSB = 12;
    localparam int ARB_MSB_POS = 11;
    localparam int PIN_POS = 7;
    localparam int LOAD_POS = 5;
    localparam int POL_POS = 4;
    localparam int EN_POS = 3;
    localparam int CLK_LSB = 0;
    localparam logic [15:0] COUNT_RESET = 16'h0001;
    localparam logic [15:0] WIDTH_ZERO = 16'h0000;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [2:0] IL_NONE = 3'h0;

    typedef struct packed {
        logic [2:0] irq_level;
        logic arb_priority_msb;
        logic output_polarity;
        logic enable;
        logic [2:0] clk_sel;
    } pss_ctrl_s;

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] width;
    } pss_pair_s;
endpackage : pss_pkg

// >>> hw/pss_prescaler.sv
// Prescaler: free counter in reset while disabled, one-cycle tick at the selected rate.
// Assumes pclk is the system clock; rates are fsys/2 .. fsys/128, then fsys/512.
`timescale 1ns/1ps
module pss_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    output logic tick
);
    logic [8:0] div_ff;
    logic [8:0] mask;

    always_comb begin
        mask = (clk_sel == 3'h7) ? 9'h1ff : 9'((9'h2 << clk_sel) - 9'h1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 9'h000;
        end else if (!run) begin
            div_ff <= 9'h000;
        end else begin
            div_ff <= 9'(div_ff + 9'h1);
        end
    end

    assign tick = run && ((div_ff & mask) == mask);
endmodule : pss_prescaler

// >>> hw/pss_pwm_submodule.sv
// Top of the PWM submodule: APB registers, period engine, flag and interrupt request.
// Assumes an APB master on pclk and an external load on the output pin.
`timescale 1ns/1ps
module pss_pwm_submodule (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic iack,
    input wire logic [2:0] iack_mask,
    output logic [7:1] irq_n,
    output logic iack_resp,
    output logic [3:0] arb_number,
    output logic pwm_out
);
    pss_pkg::pss_ctrl_s ctrl_ff;
    pss_pkg::pss_pair_s staged_ff;
    pss_pkg::pss_pair_s active_ff;
    logic [15:0] count_ff;
    logic [2:0] arb_low_ff;
    logic flag_ff;
    logic flag_seen_ff;
    logic out_ff;
    logic en_prev_ff;
    logic pin_ff;
    logic [31:0] nxt_prdata;
    logic [7:1] nxt_irq_n;
    logic wr_acc;
    logic rd_acc;
    logic ctrl_wr;
    logic load_cmd;
    logic en_rise;
    logic tick;
    logic period_end;
    logic width_hit;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign ctrl_wr = wr_acc && paddr == pss_pkg::REG_CTRL_OFS && pstrb[1:0] == 2'h3;
    assign load_cmd = ctrl_wr && pwdata[pss_pkg::LOAD_POS] && ctrl_ff.enable;
    assign en_rise = ctrl_ff.enable && !en_prev_ff;
    assign period_end = ctrl_ff.enable && !en_rise && tick && count_ff >= active_ff.period;
    assign width_hit = ctrl_ff.enable && !en_rise && tick && count_ff >= active_ff.width;

    pss_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_ff.enable && !load_cmd),
        .clk_sel(ctrl_ff.clk_sel),
        .tick(tick)
    );

    // Control register and arbitration field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            arb_low_ff <= 3'h0;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff.irq_level <= pwdata[pss_pkg::IL_LSB +: 3];
                ctrl_ff.arb_priority_msb <= pwdata[pss_pkg::ARB_MSB_POS];
                ctrl_ff.output_polarity <= pwdata[pss_pkg::POL_POS];
                ctrl_ff.enable <= pwdata[pss_pkg::EN_POS];
                ctrl_ff.clk_sel <= pwdata[pss_pkg::CLK_LSB +: 3];
            end
            if (wr_acc && paddr == pss_pkg::REG_ARB_OFS && pstrb[0]) begin
                arb_low_ff <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged_ff <= '0;
        end else if (wr_acc) begin
            if (paddr == pss_pkg::REG_PERIOD_OFS && pstrb[1:0] == 2'h3) begin
                staged_ff.period <= pwdata[15:0];
            end
            if (paddr == pss_pkg::REG_WIDTH_OFS && pstrb[1:0] == 2'h3) begin
                staged_ff.width <= pwdata[15:0];
            end
        end
    end

    // Active buffers follow staging while disabled, reload at period end or load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= '0;
        end else if (!ctrl_ff.enable || load_cmd || period_end) begin
            active_ff <= staged_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= ctrl_ff.enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= pss_pkg::COUNT_RESET;
        end else if (!ctrl_ff.enable || load_cmd || en_rise || period_end) begin
            count_ff <= pss_pkg::COUNT_RESET;
        end else if (tick) begin
            count_ff <= 16'(count_ff + 16'h1);
        end
    end

    // Output flip-flop; a load sets it unless the staged width is zero, so a high pulse never drops and rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
        end else if (!ctrl_ff.enable) begin
            out_ff <= 1'b0;
        end else if (load_cmd) begin
            out_ff <= staged_ff.width != pss_pkg::WIDTH_ZERO;
        end else if (en_rise) begin
            out_ff <= 1'b1;
        end else if (period_end) begin
            out_ff <= staged_ff.width != pss_pkg::WIDTH_ZERO;
        end else if (width_hit) begin
            out_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (out_ff && ctrl_ff.enable) ^ ctrl_ff.output_polarity;
        end
    end

    // Pin status mirrors the driven pin; the registered output is already in pclk domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= pwm_out;
        end
    end

    // Completion flag: set beats clear, clear only while disabled or after a read showed one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else if (!ctrl_ff.enable) begin
            flag_ff <= 1'b0;
        end else if (en_rise || load_cmd || period_end) begin
            flag_ff <= 1'b1;
        end else if (ctrl_wr && !pwdata[pss_pkg::FLAG_POS] && flag_seen_ff) begin
            flag_ff <= 1'b0;
        end
    end

    // Arms on the returned data, so a flag set during the access cannot arm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_seen_ff <= 1'b0;
        end else if (!ctrl_ff.enable || ctrl_wr) begin
            flag_seen_ff <= 1'b0;
        end else if (rd_acc && paddr == pss_pkg::REG_CTRL_OFS && prdata[pss_pkg::FLAG_POS]) begin
            flag_seen_ff <= 1'b1;
        end
    end

    // One request line per level; level zero selects none
    for (genvar g = 1; g < 8; g++) begin : g_irq
        assign nxt_irq_n[g] = !(flag_ff && ctrl_ff.irq_level == 3'(g));
    end

    // Interrupt request lines and acknowledge answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n <= 7'h7f;
            iack_resp <= 1'b0;
            arb_number <= 4'h0;
        end else begin
            irq_n <= nxt_irq_n;
            iack_resp <= iack && flag_ff && ctrl_ff.irq_level != pss_pkg::IL_NONE
                && iack_mask == ctrl_ff.irq_level;
            arb_number <= {ctrl_ff.arb_priority_msb, arb_low_ff};
        end
    end

    // APB read mux; always ready, unmapped reads zero and error
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            pss_pkg::REG_CTRL_OFS: begin
                nxt_prdata[pss_pkg::FLAG_POS] = flag_ff;
                nxt_prdata[pss_pkg::IL_LSB +: 3] = ctrl_ff.irq_level;
                nxt_prdata[pss_pkg::ARB_MSB_POS] = ctrl_ff.arb_priority_msb;
                nxt_prdata[pss_pkg::PIN_POS] = pin_ff;
                nxt_prdata[pss_pkg::LOAD_POS] = 1'b0;
                nxt_prdata[pss_pkg::POL_POS] = ctrl_ff.output_polarity;
                nxt_prdata[pss_pkg::EN_POS] = ctrl_ff.enable;
                nxt_prdata[pss_pkg::CLK_LSB +: 3] = ctrl_ff.clk_sel;
            end
            pss_pkg::REG_PERIOD_OFS: nxt_prdata[15:0] = staged_ff.period;
            pss_pkg::REG_WIDTH_OFS: nxt_prdata[15:0] = staged_ff.width;
            pss_pkg::REG_COUNT_OFS: nxt_prdata[15:0] = count_ff;
            pss_pkg::REG_ARB_OFS: nxt_prdata[2:0] = arb_low_ff;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= nxt_prdata;
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != pss_pkg::REG_CTRL_OFS && paddr != pss_pkg::REG_PERIOD_OFS
                && paddr != pss_pkg::REG_WIDTH_OFS && paddr != pss_pkg::REG_COUNT_OFS
                && paddr != pss_pkg::REG_ARB_OFS;
        end
    end

    property disabled_quiet_p;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_ff.enable |=> !flag_ff && count_ff == pss_pkg::COUNT_RESET;
    endproperty
    flag_off_a: assert property (disabled_quiet_p) else $error("flag or counter active while disabled");

    enable_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        en_rise |=> flag_ff && out_ff) else $error("enable did not set flag and output");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_ff && ctrl_ff.enable && !ctrl_wr |=> flag_ff) else $error("flag dropped without a write");

    sequence read_one_s;
        rd_acc && paddr == pss_pkg::REG_CTRL_OFS && prdata[pss_pkg::FLAG_POS] && ctrl_ff.enable;
    endsequence
    sequence zero_write_s;
        ctrl_wr && !pwdata[pss_pkg::FLAG_POS] && ctrl_ff.enable && !en_rise && !load_cmd && !period_end;
    endsequence
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(flag_ff) && ctrl_ff.enable |-> $past(flag_seen_ff)) else $error("flag cleared without read");

    period_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end |=> flag_ff) else $error("period end did not set flag");

    irq_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_ff && ctrl_ff.irq_level == 3'h7 && $stable(ctrl_ff.irq_level) && $stable(flag_ff) |=> !irq_n[7])
        else $error("interrupt line not asserted");

    load_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_cmd |=> count_ff == pss_pkg::COUNT_RESET && flag_ff && active_ff == $past(staged_ff))
        else $error("load did not restart period");

    load_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_cmd && staged_ff.width == pss_pkg::WIDTH_ZERO |=> !out_ff) else $error("zero width set output");

    pol_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.enable [*2] |-> pwm_out == $past(ctrl_ff.output_polarity)) else $error("idle pin level wrong");

    load_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == pss_pkg::REG_CTRL_OFS |-> !prdata[pss_pkg::LOAD_POS]) else $error("load bit read one");

    flag_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_one_s |=> flag_seen_ff) else $error("read of one did not arm clear");

    clear_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
        read_one_s ##1 (!ctrl_wr) [*2] ##1 zero_write_s |=> !flag_ff)
        else $error("read then zero write kept flag");

    load_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr && pwdata[pss_pkg::LOAD_POS] && !ctrl_ff.enable |=> !flag_ff && !out_ff)
        else $error("load acted while disabled");

    disabled_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.enable |=> active_ff == $past(staged_ff)) else $error("active buffers not following staging");

    enable_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        en_rise |=> count_ff == pss_pkg::COUNT_RESET) else $error("enable did not restart counter");

    width_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        width_hit && !period_end && !load_cmd |=> !out_ff) else $error("width match did not clear output");

    period_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        period_end && !load_cmd |=> count_ff == pss_pkg::COUNT_RESET && active_ff == $past(staged_ff))
        else $error("period end did not reload");

    load_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_cmd && out_ff && staged_ff.width != pss_pkg::WIDTH_ZERO |=> out_ff)
        else $error("load dropped a high output");

    irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flag_ff || ctrl_ff.irq_level == pss_pkg::IL_NONE |=> irq_n == 7'h7f) else $error("request without cause");

    irq_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(~irq_n)) else $error("more than one request line low");

    iack_match_a: assert property (@(posedge pclk) disable iff (!presetn)
        iack && iack_mask != ctrl_ff.irq_level |=> !iack_resp) else $error("answered a foreign mask");

    arb_join_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> arb_number[3] == $past(ctrl_ff.arb_priority_msb) && arb_number[2:0] == $past(arb_low_ff))
        else $error("arbitration number wrong");

    pin_echo_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> pin_ff == $past(pwm_out)) else $error("pin status not following pin");
endmodule : pss_pwm_submodule

// >>> verification/pss_load_model.sv
// Load model: the external load on the modulated pin, counting the rising edges it sees.
// Assumes the pin changes only just after rising edges of pclk.
`timescale 1ns/1ps
module pss_load_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output int rise_count
);
    logic last_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b0;
            rise_count <= 0;
        end else begin
            last_ff <= pin;
            if (pin && !last_ff) begin
                rise_count <= rise_count + 1;
            end
        end
    end
endmodule : pss_load_model

// >>> verification/testbench.sv
// Testbench: APB master, acknowledge driver and checks on pin, request lines and readback.
// Assumes the submodule top and the load model; one 40 MHz clock, async reset.
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, iack = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h2542;
    logic [3:0] pstrb = 4'h0, arb_number;
    logic [2:0] iack_mask = 3'h0, lo;
    logic [7:1] irq_n;
    logic [15:0] per;
    logic pready, pslverr, iack_resp, pwm_out, err;
    int fail_count = 0, cmp_count = 0, rises, n, hi;

    always #12.5 pclk = ~pclk;

    pss_pwm_submodule DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .iack(iack), .iack_mask(iack_mask), .irq_n(irq_n), .iack_resp(iack_resp), .arb_number(arb_number),
        .pwm_out(pwm_out));
    pss_load_model LOAD (.pclk(pclk), .presetn(presetn), .pin(pwm_out), .rise_count(rises));

    function logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Control word with the divider at its fastest setting
    function automatic logic [31:0] cw(input logic f, input logic [2:0] l, input logic m, input logic ld,
        input logic p, input logic e);
        return {16'h0, f, l, m, 5'h00, ld, p, e, 3'h0};
    endfunction : cw

    function automatic logic [7:1] exp_irq(input logic [2:0] l);
        logic [7:1] v;
        v = 7'h7f;
        if (l != 3'h0) v[l] = 1'b0;
        return v;
    endfunction : exp_irq

    // High cycles of one period at the fastest divider: two clocks per counter step
    function automatic int exp_high(input logic [15:0] wd);
        return 2 * int'(wd);
    endfunction : exp_high

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task finish_test();
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        int w;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0);
        check(rd & 32'h0000f8bf, 0);
        apb(0, 8'h0c, 0);
        check(rd, 1);
        apb(0, 8'hfc, 0);
        check(err, 1);
        apb(1, 8'h04, 200);
        apb(1, 8'h08, 100);
        // Flag write of one and load, both while disabled
        apb(1, 8'h00, cw(1, 3'h0, 0, 1, 1, 0));
        repeat (4) @(posedge pclk);
        check(pwm_out, 1);
        apb(0, 8'h00, 0);
        check(rd[15], 0);
        check(rd[7], 1);
        apb(1, 8'h00, cw(0, 3'h0, 0, 0, 0, 0));
        repeat (4) @(posedge pclk);
        check(pwm_out, 0);
        check(irq_n, 7'h7f);
        for (int l = 1; l < 8; l++) begin
            per = 16'd200 + 16'(rnd() & 32'h3f);
            lo = 3'(rnd());
            apb(1, 8'h04, {16'h0, per});
            apb(1, 8'h08, {17'h0, per[15:1]});
            apb(1, 8'h10, {29'h0, lo});
            apb(1, 8'h00, cw(0, 3'(l), l[0], 0, 0, 1));
            repeat (4) @(posedge pclk);
            check(irq_n, exp_irq(3'(l)));
            check(pwm_out, 1);
            check(arb_number, {l[0], lo});
            iack <= 1'b1;
            iack_mask <= 3'(l);
            repeat (3) @(posedge pclk);
            check(iack_resp, 1);
            iack_mask <= 3'(l) ^ 3'h1;
            repeat (3) @(posedge pclk);
            check(iack_resp, 0);
            iack <= 1'b0;
            // Zero written before any read of one must not clear
            apb(1, 8'h00, cw(0, 3'(l), l[0], 0, 0, 1));
            apb(0, 8'h00, 0);
            check(rd[15], 1);
            apb(1, 8'h00, cw(0, 3'(l), l[0], 1, 0, 1));
            apb(0, 8'h0c, 0);
            check(rd inside {[1:4]}, 1);
            apb(0, 8'h00, 0);
            check(rd[15], 1);
            check(rd[5], 0);
            apb(1, 8'h00, cw(0, 3'(l), l[0], 0, 0, 1));
            apb(0, 8'h00, 0);
            check(rd[15], 0);
            check(irq_n, 7'h7f);
            w = 0;
            while (irq_n[l] !== 1'b0 && w < 4 * per) begin
                @(posedge pclk);
                w++;
            end
            if (w == 4 * per) begin
                fail_count++;
                finish_test();
            end
            // Window of exactly three periods, so the phase at which it starts does not matter
            n = rises;
            hi = 0;
            repeat (6 * per) begin
                @(posedge pclk);
                hi += (pwm_out === 1'b1) ? 1 : 0;
            end
            check((rises - n) inside {[2:4]}, 1);
            check(hi, 3 * exp_high(per >> 1));
            apb(1, 8'h00, cw(0, 3'(l), l[0], 0, 0, 0));
            apb(0, 8'h00, 0);
            check(rd[15], 0);
            apb(0, 8'h0c, 0);
            check(rd, 1);
        end
        apb(1, 8'h00, cw(0, 3'h7, 0, 0, 0, 1));
        apb(1, 8'h08, 0);
        apb(1, 8'h00, cw(0, 3'h7, 0, 1, 0, 1));
        n = rises;
        repeat (4 * per) @(posedge pclk);
        check(pwm_out, 0);
        check(rises - n, 0);
        finish_test();
    end
endmodule : testbench
